/* File: lss_map.svh */
// Constants for the low-side switch control block: word layout, reset values and timing.
// Assumes a 125 MHz system clock; dead and settle times are kept in ns and turned into cycles by the control block.
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

`define LSS_NUM_OUTPUTS 6
`define LSS_WORD_BITS 8
`define LSS_CMD_SLEEP_BIT 7
`define LSS_CMD_RESET 8'h80
`define LSS_STAT_RESET 8'h00
`define LSS_STAT_DUAL_BIT 6
`define LSS_SYS_PERIOD_NS 8
`define LSS_WAKEUP_DEAD_NS 40000
`define LSS_MODE_SETTLE_NS 10000
`define LSS_FAULT_FILTER_CYC 250
`define LSS_RETRY_OFF_CYC 1250

`endif

/* File: lss_pkg.sv */
// Types shared by the low-side switch control block.
// Assumes lss_map.svh is on the include path.
`include "lss_map.svh"

package lss_pkg;

   // Command word as shifted in from the serial port
   typedef struct packed
   {
      logic sleep_en;
      logic spare;
      logic [`LSS_NUM_OUTPUTS-1:0] on;
   } cmd_word_type;

   // Status word as shifted out on the serial port
   typedef struct packed
   {
      logic zero;
      logic dual;
      logic [`LSS_NUM_OUTPUTS-1:0] fault;
   } stat_word_type;

   // Digital results of the analog sense circuits
   typedef struct packed
   {
      logic overvoltage_sense;
      logic mode_mid_level;
      logic [`LSS_NUM_OUTPUTS-1:0] out_high;
   } sense_type;

   typedef enum logic [1:0] {st_dead, st_active, st_sleep} ctl_state_type;

endpackage

/* File: fault_channel.sv */
// One output's fault filter, fault latches and short-circuit retry timer.
// Assumes synchronous inputs on clk_sys; high_sense is already synchronised.
`timescale 1ns/100ps
`include "lss_map.svh"

module fault_channel
#(
   parameter int FILTER_CYCLES = `LSS_FAULT_FILTER_CYC,
   parameter int RETRY_CYCLES = `LSS_RETRY_OFF_CYC
)
(
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Asynchronous reset, high
   input wire logic detect_en, // Fault detection allowed
   input wire logic drive_req, // Output commanded on
   input wire logic high_sense, // Output voltage above the sense threshold
   input wire logic flag_clear, // Clear both fault latches
   output logic drive_gate, // Low while the retry-off time runs
   output logic short_flag, // Latched current-limit fault
   output logic open_flag // Latched open-load fault
);

   localparam int FW = $clog2(FILTER_CYCLES + 1);
   localparam int RW = $clog2(RETRY_CYCLES + 1);
   localparam logic [FW-1:0] FILTER_LAST = FW'(FILTER_CYCLES - 1);
   localparam logic [RW-1:0] RETRY_LOAD = RW'(RETRY_CYCLES);

   logic [FW-1:0] filt_q;
   logic [FW-1:0] filt_d;
   logic [RW-1:0] retry_q;
   logic [RW-1:0] retry_d;
   logic req_prev_q;
   logic short_q;
   logic open_q;

   wire retry_active = (retry_q != '0);
   wire cond_short = detect_en & drive_req & ~retry_active & high_sense;
   wire cond_open = detect_en & ~drive_req & ~high_sense;
   wire cond_any = cond_short | cond_open;
   // A change of command restarts the filter so the two fault kinds never share time
   wire filt_restart = flag_clear | ~cond_any | (drive_req != req_prev_q);
   wire filt_hit = cond_any & ~filt_restart & (filt_q == FILTER_LAST);
   wire short_set = filt_hit & cond_short; // see R1
   wire open_set = filt_hit & cond_open; // see R2

   assign filt_d = filt_restart ? '0 : ((filt_q > FILTER_LAST) ? filt_q : filt_q + FW'(1));
   assign retry_d = short_set ? RETRY_LOAD : (retry_active ? retry_q - RW'(1) : retry_q);

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         filt_q <= '0;
         retry_q <= '0;
         req_prev_q <= 1'b0;
         short_q <= 1'b0;
         open_q <= 1'b0;
      end
      else
      begin
         filt_q <= filt_d;
         retry_q <= detect_en ? retry_d : '0;
         req_prev_q <= drive_req;
         short_q <= short_set | (short_q & ~flag_clear); // see R3, R15
         open_q <= open_set | (open_q & ~flag_clear); // see R3, R15
      end
   end

   assign drive_gate = ~retry_active; // see R1
   assign short_flag = short_q;
   assign open_flag = open_q;

endmodule

/* File: spi_low_side_switch_control.sv */
// Control logic of a six-output low-side switch: serial port, output selection,
// mode detection, sleep and wake-up timing, overvoltage shutdown and fault reporting.
// Assumes the analog comparators deliver digital levels and the serial clock is
// driven by an external master only while chip select is low.
//
// Notes on behaviour
// R1: Output in current limit past the filter time is turned off, then retried.
// R2: Commanded-off output staying low past the filter time flags open load.
// R3: Current-limit and open-load faults are latched and shifted out.
// R4: Hex mode: outputs 0 to 2 follow direct input OR command bit.
// R5: Hex mode: outputs 3 to 5 follow command bits 3 to 5 only.
// R6: Dual mode: outputs 0, 4, 5 on by direct input 0 or bits 0, 4, 5 all set.
// R7: Dual mode: outputs 1, 2, 3 on by direct input 1 or bits 1, 2, 3 all set.
// R8: Direct inputs ignored while chip activate is high and sleep bit is set.
// R9: Intermediate mode level held over 10 us selects dual; clean level keeps hex.
// R10: Serial input sampled on rising clock, output changes on falling clock.
// R11: Chip select falling presents bit 7; each falling clock shifts the next bit.
// R12: First captured input bit reappears on the eighth falling clock edge.
// R13: Serial output is not driven while chip select is high.
// R14: Chip select rising takes the shifted-in bits as the new command.
// R15: Chip select rising clears fault latches; lasting faults latch again later.
// R16: Power-up or wake from sleep starts a 40 us dead time with outputs off.
// R17: Chip activate falling outside sleep acts at once, with no dead time.
// R18: Sleep bit set and chip activate high: sleep, clear command and faults.
// R19: Overvoltage forces every output off until it clears.
// R20: The command word is eight bits long.
// R21: Full control only while chip activate is low.
// R22: The sleep bit is set after power-up.
// R23: In sleep all outputs are off, serial port ignored, no fault detection.
// R24: Filter, retry and dead times are parameters counted in clock cycles.
// R25: Fault bit n of the status word belongs to output n.
// R26: Serial clock and chip select are crossed properly into the system clock.
`timescale 1ns/100ps
`include "lss_map.svh"

module spi_low_side_switch_control
   import lss_pkg::*;
#(
   parameter int FAULT_FILTER_CYCLES = `LSS_FAULT_FILTER_CYC, // see R24
   parameter int RETRY_OFF_CYCLES = `LSS_RETRY_OFF_CYC, // see R24
   parameter int WAKEUP_DEAD_CYCLES =
      (`LSS_WAKEUP_DEAD_NS + `LSS_SYS_PERIOD_NS - 1) / `LSS_SYS_PERIOD_NS, // see R24
   parameter int MODE_SETTLE_CYCLES =
      (`LSS_MODE_SETTLE_NS + `LSS_SYS_PERIOD_NS - 1) / `LSS_SYS_PERIOD_NS
)
(
   input wire logic clk_sys, // System clock, 125 MHz
   input wire logic sys_rst, // Asynchronous reset, high; acts as power-up
   input wire logic spi_sclk, // Serial clock from the master
   input wire logic spi_cs_n, // Chip select, low
   input wire logic spi_si, // Serial data in
   output logic spi_so_out, // Serial data out, level
   output logic spi_so_oe, // Serial data out enable, high drives
   input wire logic direct_in_0, // Direct control input 0
   input wire logic direct_in_1, // Direct control input 1
   input wire logic direct_in_2_mode_select, // Direct input 2, clean-level reading
   input wire logic chip_activate_n, // Chip activate, low
   input wire sense_type sense, // Comparator results, asynchronous
   output logic [`LSS_NUM_OUTPUTS-1:0] switch_outputs, // Gate drive, high turns on
   output logic dual_mode, // High in dual mode
   output logic sleeping, // High while in sleep
   output logic [`LSS_NUM_OUTPUTS-1:0] fault_short, // Latched current-limit faults
   output logic [`LSS_NUM_OUTPUTS-1:0] fault_open // Latched open-load faults
);

   localparam int N = `LSS_NUM_OUTPUTS;
   localparam int SW = 5 + N + 2;
   localparam int DW = $clog2(WAKEUP_DEAD_CYCLES + 1);
   localparam int MW = $clog2(MODE_SETTLE_CYCLES + 1);
   localparam logic [DW-1:0] DEAD_LAST = DW'(WAKEUP_DEAD_CYCLES - 1);
   localparam logic [MW-1:0] MODE_LAST = MW'(MODE_SETTLE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Link domain: shift path on the serial clock

   logic [`LSS_WORD_BITS-1:0] rx_q;
   logic [3:0] edge_cnt_q;
   logic so_q;
   stat_word_type snap_q;

   wire [2:0] tx_sel = 3'(3'd7 - edge_cnt_q[2:0]);
   wire [`LSS_WORD_BITS-1:0] tx_word = snap_q;
   wire tx_bit = edge_cnt_q[3] ? rx_q[`LSS_WORD_BITS-1] : tx_word[tx_sel]; // see R12

   // Input bits are sampled while selected only; held after the frame for the latch
   always_ff @(posedge spi_sclk or posedge sys_rst)
   begin
      if (sys_rst)
         rx_q <= '0;
      else if (!spi_cs_n)
         rx_q <= {rx_q[`LSS_WORD_BITS-2:0], spi_si}; // see R10, R20
   end

   // Chip select high holds the count at zero
   always_ff @(posedge spi_sclk or posedge spi_cs_n)
   begin
      if (spi_cs_n)
         edge_cnt_q <= 4'h0;
      else if (!edge_cnt_q[3])
         edge_cnt_q <= edge_cnt_q + 4'h1;
   end

   // Status bit 7 is always zero, so clearing on chip select presents it at once
   always_ff @(negedge spi_sclk or posedge spi_cs_n)
   begin
      if (spi_cs_n)
         so_q <= 1'b0; // see R11
      else
         so_q <= tx_bit; // see R10, R11
   end

   assign spi_so_out = so_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for every asynchronous input

   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;

   wire [SW-1:0] async_in = {spi_cs_n, chip_activate_n, direct_in_2_mode_select,
                             direct_in_1, direct_in_0, sense};

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sync1_q <= {2'b11, {(SW-2){1'b0}}};
         sync2_q <= {2'b11, {(SW-2){1'b0}}};
      end
      else
      begin
         sync1_q <= async_in; // see R26
         sync2_q <= sync1_q;
      end
   end

   sense_type sense_s;
   assign sense_s = sync2_q[N+1:0];
   wire [2:0] direct_s = sync2_q[N+4:N+2];
   wire en_high_s = sync2_q[N+5];
   wire cs_high_s = sync2_q[N+6];

   ////////////////////////////////////////////////////////////////////////////////
   // Frame edges, command latch and status snapshot

   logic cs_prev_q;
   logic en_prev_q;
   cmd_word_type cmd_q;
   ctl_state_type state_q;
   ctl_state_type state_d;

   wire cs_rise = cs_high_s & ~cs_prev_q;
   wire en_fall = ~en_high_s & en_prev_q;
   wire in_sleep = (state_q == st_sleep);
   // Only an active block falls asleep, so the power-up sleep bit outlives the dead time
   wire go_sleep = (state_q == st_active) & en_high_s & cmd_q.sleep_en; // see R18, R22, R23
   wire cmd_take = cs_rise & ~in_sleep & ~go_sleep; // see R14, R23

   stat_word_type stat_now;
   logic [N-1:0] short_w;
   logic [N-1:0] open_w;
   logic dual_q;

   assign stat_now.zero = 1'b0;
   assign stat_now.dual = dual_q;
   assign stat_now.fault = short_w | open_w; // see R3, R25

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cs_prev_q <= 1'b1;
         en_prev_q <= 1'b1;
         cmd_q <= `LSS_CMD_RESET; // see R22
      end
      else
      begin
         cs_prev_q <= cs_high_s;
         en_prev_q <= en_high_s;
         if (go_sleep || in_sleep)
            cmd_q <= '0; // see R18
         else if (cmd_take)
            cmd_q <= rx_q; // see R14
      end
   end

   // Frozen while selected so the link side reads a steady word
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         snap_q <= `LSS_STAT_RESET;
      else if (cs_high_s)
         snap_q <= stat_now; // see R26
   end

   // Enable follows chip select after the synchroniser, well inside the lead time
   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
         spi_so_oe <= 1'b0;
      else
         spi_so_oe <= ~cs_high_s; // see R13
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Power-up, sleep and wake-up dead time

   // Dead-time counter runs only in the dead state and rests at zero elsewhere
   logic [DW-1:0] dead_q;
   wire dead_done = (dead_q == DEAD_LAST);

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         st_dead:
            if (dead_done)
               state_d = st_active; // see R16
         st_active:
            if (go_sleep)
               state_d = st_sleep; // see R18
         st_sleep:
            if (en_fall)
               state_d = st_dead; // see R16
         default:
            state_d = st_dead;
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= st_dead;
         dead_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         dead_q <= (state_q == st_dead && !dead_done) ? dead_q + DW'(1) : '0;
      end
   end

   // Waking outside sleep needs no timer: active state simply persists
   wire active = (state_q == st_active); // see R17

   ////////////////////////////////////////////////////////////////////////////////
   // Mode detection on the direct input 2 pin

   logic [MW-1:0] mode_cnt_q;
   wire mode_hit = sense_s.mode_mid_level & (mode_cnt_q == MODE_LAST);

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         mode_cnt_q <= '0;
         dual_q <= 1'b0;
      end
      else
      begin
         if (!sense_s.mode_mid_level)
            mode_cnt_q <= '0;
         else if (!mode_hit)
            mode_cnt_q <= mode_cnt_q + MW'(1);
         if (!sense_s.mode_mid_level)
            dual_q <= 1'b0; // see R9
         else if (mode_hit)
            dual_q <= 1'b1; // see R9
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output selection

   // Serial bits only steer outputs while chip activate is low
   wire spi_ok = active & ~en_high_s; // see R21, R16
   wire direct_ok = active & ~(en_high_s & cmd_q.sleep_en); // see R8, R16
   wire [N-1:0] spi_on = cmd_q.on & {N{spi_ok}};
   wire [2:0] dir_on = direct_s & {3{direct_ok}};

   wire [N-1:0] hex_req = {spi_on[5:3], spi_on[2:0] | dir_on}; // see R4, R5
   wire grp0 = dir_on[0] | (spi_on[0] & spi_on[4] & spi_on[5]); // see R6
   wire grp1 = dir_on[1] | (spi_on[1] & spi_on[2] & spi_on[3]); // see R7
   wire [N-1:0] dual_req = {grp0, grp0, grp1, grp1, grp1, grp0};
   wire [N-1:0] drive_req = dual_q ? dual_req : hex_req;

   wire detect_en = active & ~sense_s.overvoltage_sense; // see R23
   wire fault_clear = cs_rise | go_sleep | in_sleep; // see R15, R18
   logic [N-1:0] gate_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Per-output fault channels

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_chan
         fault_channel #(
            .FILTER_CYCLES(FAULT_FILTER_CYCLES),
            .RETRY_CYCLES(RETRY_OFF_CYCLES)
         ) u_chan (
            .clk_sys(clk_sys),
            .sys_rst(sys_rst),
            .detect_en(detect_en),
            .drive_req(drive_req[gi]),
            .high_sense(sense_s.out_high[gi]),
            .flag_clear(fault_clear),
            .drive_gate(gate_w[gi]),
            .short_flag(short_w[gi]),
            .open_flag(open_w[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Registered outputs

   wire [N-1:0] out_d = drive_req & gate_w & {N{active & ~sense_s.overvoltage_sense}}; // see R19

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         switch_outputs <= '0;
         dual_mode <= 1'b0;
         sleeping <= 1'b0;
         fault_short <= '0;
         fault_open <= '0;
      end
      else
      begin
         switch_outputs <= out_d; // see R1, R16, R23
         dual_mode <= dual_q;
         sleeping <= in_sleep;
         fault_short <= short_w;
         fault_open <= open_w;
      end
   end

endmodule

/* File: lss_master_model.sv */
// Serial master model for the switch control bench, frames of 8 or 16 bits.
// Assumes the slave samples on the rising clock and shifts on the falling one.
`timescale 1ns/100ps

module lss_master_model
(
   output logic spi_sclk, // Serial clock, low between frames
   output logic spi_cs_n, // Chip select, low
   output logic spi_si, // Serial data to the slave
   input wire logic spi_so // Serial data from the slave
);
   initial
   begin
      spi_sclk = 1'h0;
      spi_cs_n = 1'h1;
      spi_si = 1'h0;
   end

   // Clock period 12 ns; it stands still low outside frames
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = '0;
      // Start off the system clock edge so the link stays unrelated in phase
      #3;
      spi_cs_n = 1'h0;
      // Lead time also covers the output enable lag
      #120;
      for (int i = n - 1; i >= 0; i--)
      begin
         spi_si = tx[i];
         #6 spi_sclk = 1'h1;
         rx[i] = spi_so;
         #6 spi_sclk = 1'h0;
      end
      #6 spi_cs_n = 1'h1;
      // Released data line falls to its pull-down level
      spi_si = 1'h0;
      #60;
   endtask
endmodule

/* File: lss_ctl_props.sv */
// Assertions for the switch control block, bound to its top module.
// Assumes one clk_sys domain; serial pins are watched as sampled levels.
`timescale 1ns/100ps
`include "lss_map.svh"

module lss_ctl_props
   import lss_pkg::*;
#(
   parameter int WAKEUP_DEAD_CYCLES = 20,
   parameter int RETRY_OFF_CYCLES = 8,
   parameter int MODE_SETTLE_CYCLES = 8
)
(
   input wire logic clk_sys, // System clock
   input wire logic sys_rst, // Reset, high
   input wire logic spi_cs_n, // Chip select
   input wire logic spi_so_oe, // Serial output enable
   input wire logic direct_in_0, // Direct input 0
   input wire sense_type sense, // Comparator results
   input wire logic [`LSS_NUM_OUTPUTS-1:0] switch_outputs, // Gate drives
   input wire logic dual_mode, // Dual mode flag
   input wire logic sleeping, // Sleep flag
   input wire logic [`LSS_NUM_OUTPUTS-1:0] fault_short, // Short latches
   input wire logic [`LSS_NUM_OUTPUTS-1:0] fault_open // Open latches
);
   int calm_q;
   int mid_q;
   logic calm_ok;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // Quiet time since sleep, short or overvoltage; covers dead and retry times
   assign calm_ok = calm_q > WAKEUP_DEAD_CYCLES + RETRY_OFF_CYCLES + 8;

   always_ff @(posedge clk_sys or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         calm_q <= 0;
         mid_q <= 0;
      end
      else
      begin
         calm_q <= (sleeping || fault_short != '0 || sense.overvoltage_sense) ? 0 :
            (calm_q < 4095) ? calm_q + 1 : calm_q;
         mid_q <= !sense.mode_mid_level ? 0 : (mid_q < 4095) ? mid_q + 1 : mid_q;
      end
   end

   sequence s_ov_held;
      sense.overvoltage_sense [*4];
   endsequence

   sequence s_gate_off;
      (!switch_outputs[1]) [*5];
   endsequence

   a_ov_all_off: assert property (s_ov_held |-> switch_outputs == '0)
      else $error("outputs on during overvoltage");
   a_sleep_quiet: assert property (sleeping [*3] |->
      switch_outputs == '0 && fault_short == '0 && fault_open == '0)
      else $error("activity while sleeping");
   a_so_released: assert property (spi_cs_n [*4] |-> !spi_so_oe)
      else $error("serial output driven while deselected");
   a_so_driven: assert property (!spi_cs_n [*4] |-> spi_so_oe)
      else $error("serial output not driven in frame");
   a_direct_on: assert property ((calm_ok && direct_in_0) [*4] |-> switch_outputs[0])
      else $error("direct input 0 ignored");
   a_dual_groups: assert property ((calm_ok && dual_mode) [*4] |->
      switch_outputs[0] == switch_outputs[4] && switch_outputs[4] == switch_outputs[5] &&
      switch_outputs[1] == switch_outputs[2] && switch_outputs[2] == switch_outputs[3])
      else $error("dual groups split");
   a_dual_settle: assert property ($rose(dual_mode) |-> mid_q >= MODE_SETTLE_CYCLES)
      else $error("dual mode entered early");
   a_dual_reached: assert property (mid_q > MODE_SETTLE_CYCLES + 4 &&
      calm_q > MODE_SETTLE_CYCLES + 4 |-> dual_mode)
      else $error("dual mode not entered");
   a_cs_clears: assert property ($rose(spi_cs_n) && !sleeping |->
      ##[2:8] (fault_short == '0 && fault_open == '0))
      else $error("faults not cleared at deselect");
   a_short_retry: assert property ($rose(fault_short[1]) |-> ##[0:2] s_gate_off)
      else $error("shorted output not turned off");
endmodule

bind spi_low_side_switch_control lss_ctl_props #(
   .WAKEUP_DEAD_CYCLES(WAKEUP_DEAD_CYCLES),
   .RETRY_OFF_CYCLES(RETRY_OFF_CYCLES),
   .MODE_SETTLE_CYCLES(MODE_SETTLE_CYCLES)
) props (
   .clk_sys(clk_sys),
   .sys_rst(sys_rst),
   .spi_cs_n(spi_cs_n),
   .spi_so_oe(spi_so_oe),
   .direct_in_0(direct_in_0),
   .sense(sense),
   .switch_outputs(switch_outputs),
   .dual_mode(dual_mode),
   .sleeping(sleeping),
   .fault_short(fault_short),
   .fault_open(fault_open)
);

/* File: spi_low_side_switch_control_tb.sv */
// Self-checking bench for the switch control block: commands, direct inputs,
// modes, sleep, overvoltage and faults. Assumes lss_master_model as serial master.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin bad_count++; \
$display("BAD %s exp %h got %h", nm, ex, got); end end

module spi_low_side_switch_control_tb;
   import lss_pkg::*;
   localparam int WAKE = 20;
   localparam int FILT = 4;
   localparam int RETRY = 8;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic d0 = 1'h0, d1 = 1'h0, d2 = 1'h0, act_n = 1'h1, ov = 1'h0, mid = 1'h0;
   logic [5:0] open_m = 6'h00, short_m = 6'h00;
   logic spi_sclk, spi_cs_n, spi_si, spi_so_out, spi_so_oe, dual_mode, sleeping;
   logic [5:0] outs, f_short, f_open;
   logic [15:0] r16;
   logic [7:0] dc[4] = '{8'h31, 8'h11, 8'h0e, 8'h3f};
   logic [5:0] de[4] = '{6'h31, 6'h00, 6'h0e, 6'h3f};
   int bad_count = 0;
   int n_checks = 0;
   int k;
   sense_type sense;
   // Healthy loads pull an off output high; faults are injected by mask
   wire [5:0] hi = (~outs & ~open_m) | short_m;
   wire so_line = spi_so_oe ? spi_so_out : 1'bz;
   assign sense = '{ov, mid, hi};

   initial forever #4 clk_sys = ~clk_sys;

   lss_master_model m (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
      .spi_so(so_line));

   spi_low_side_switch_control #(.FAULT_FILTER_CYCLES(FILT), .RETRY_OFF_CYCLES(RETRY),
      .WAKEUP_DEAD_CYCLES(WAKE), .MODE_SETTLE_CYCLES(8)) dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_si(spi_si), .spi_so_out(spi_so_out), .spi_so_oe(spi_so_oe),
      .direct_in_0(d0), .direct_in_1(d1), .direct_in_2_mode_select(d2),
      .chip_activate_n(act_n), .sense(sense), .switch_outputs(outs),
      .dual_mode(dual_mode), .sleeping(sleeping), .fault_short(f_short),
      .fault_open(f_open));

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic cmd(input logic [7:0] w, input logic [7:0] st);
      logic [15:0] r;
      m.xfer({8'h00, w}, 8, r);
      `CHK("status", st, r[7:0])
      tick(8);
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #100000;
      bad_count++;
      end_of_test();
   end

   initial
   begin
      tick(8);
      sys_rst <= 1'h0;
      d0 <= 1'h1;
      tick(WAKE + 6);
      `CHK("sleep", 1'h1, sleeping)
      `CHK("outs", 6'h00, outs)
      act_n <= 1'h0;
      tick(6);
      `CHK("dead", 6'h00, outs)
      tick(WAKE + 4);
      `CHK("wake", 6'h01, outs)
      d0 <= 1'h0;
      for (int i = 0; i < 6; i++)
      begin
         cmd(8'h01 << i, 8'h00);
         `CHK("hex", 6'h01 << i, outs)
      end
      d1 <= 1'h1;
      d2 <= 1'h1;
      cmd(8'h20, 8'h00);
      `CHK("or", 6'h26, outs)
      d1 <= 1'h0;
      d2 <= 1'h0;
      m.xfer(16'h8a05, 16, r16);
      `CHK("daisy", 16'h008a, r16)
      tick(8);
      `CHK("last", 6'h05, outs)
      mid <= 1'h1;
      tick(4);
      `CHK("early", 1'h0, dual_mode)
      tick(12);
      `CHK("dual", 1'h1, dual_mode)
      for (int i = 0; i < 4; i++)
      begin
         cmd(dc[i], 8'h40);
         `CHK("group", de[i], outs)
      end
      cmd(8'h00, 8'h40);
      d1 <= 1'h1;
      tick(5);
      `CHK("dual_p1", 6'h0e, outs)
      d1 <= 1'h0;
      d0 <= 1'h1;
      tick(5);
      `CHK("dual_p0", 6'h31, outs)
      d0 <= 1'h0;
      mid <= 1'h0;
      tick(5);
      `CHK("hex_back", 1'h0, dual_mode)
      cmd(8'h3f, 8'h00);
      ov <= 1'h1;
      tick(5);
      `CHK("ov_off", 6'h00, outs)
      ov <= 1'h0;
      tick(5);
      `CHK("ov_back", 6'h3f, outs)
      cmd(8'h00, 8'h00);
      open_m <= 6'h04;
      tick(FILT + 8);
      `CHK("open", 6'h04, f_open)
      cmd(8'h00, 8'h04);
      tick(FILT + 4);
      `CHK("relatch", 6'h04, f_open)
      open_m <= 6'h00;
      cmd(8'h00, 8'h04);
      `CHK("cleared", 6'h00, f_open)
      cmd(8'h02, 8'h00);
      short_m <= 6'h02;
      tick(FILT + 6);
      `CHK("short", 6'h02, f_short)
      `CHK("short_off", 1'h0, outs[1])
      k = 0;
      while (outs[1] !== 1'h1 && k < RETRY + 20)
      begin
         tick(1);
         k++;
      end
      `CHK("retry", 1'h1, outs[1])
      short_m <= 6'h00;
      tick(2);
      cmd(8'h00, 8'h02);
      cmd(8'h87, 8'h00);
      act_n <= 1'h1;
      tick(6);
      `CHK("sleep_in", 1'h1, sleeping)
      `CHK("sleep_off", 6'h00, outs)
      d0 <= 1'h1;
      tick(5);
      `CHK("p_ignored", 6'h00, outs)
      cmd(8'h3f, 8'h00);
      act_n <= 1'h0;
      tick(WAKE + 8);
      `CHK("regs_zero", 6'h01, outs)
      d0 <= 1'h0;
      cmd(8'h01, 8'h00);
      act_n <= 1'h1;
      d1 <= 1'h1;
      tick(6);
      `CHK("no_sleep", 1'h0, sleeping)
      `CHK("spi_masked", 6'h02, outs)
      act_n <= 1'h0;
      tick(5);
      `CHK("at_once", 6'h03, outs)
      end_of_test();
   end
endmodule
